// [pkg/pmon_pkg.sv]
/*
 Shared constants, register layout and carrier types of the power monitor control block.
 Assumes a 32-bit AXI4-Lite register bus and a 12-bit converter front end.
*/
package pmon_pkg;
   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_CONVERT_PIN_CTRL = 8'h00;
   localparam logic [7:0] OFS_ALERT_EN = 8'h04;
   localparam logic [7:0] OFS_ALERT_THRESHOLD_REG = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_CUR_DATA = 8'h10;
   localparam logic [7:0] OFS_VOLT_DATA = 8'h14;

   // ----------------------------------------
   // Field layout and reset values
   // ----------------------------------------
   localparam int ADC_W = 12;
   localparam logic [1:0] MODE_NONE = 2'h0;
   localparam logic [1:0] MODE_CUR = 2'h1;
   localparam logic [1:0] MODE_VOLT = 2'h2;
   localparam logic [1:0] MODE_BOTH = 2'h3;
   localparam logic [1:0] CONVERT_PIN_MODE_RST = 2'h3;
   localparam int AEN_SRC_BIT = 0;
   localparam int AEN_CLR_BIT = 1;
   localparam logic [11:0] ALERT_THRESHOLD_REG_RST = 12'hFFF;
   localparam int ST_ALERT_BIT = 0;
   localparam int ST_BUSY_BIT = 1;
   localparam int ST_ADDR_LSB = 8;
   localparam logic [2:0] SLAVE_ADDR_BASE = 3'h3;
   localparam logic CHAN_CUR = 1'b0;
   localparam logic CHAN_VOLT = 1'b1;

   // ----------------------------------------
   // Bus answers
   // ----------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [ADC_W-1:0] cur;
      logic [ADC_W-1:0] volt;
   } convert_pin_result_s;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_CUR = 2'b01,
      SEQ_VOLT = 2'b10
   } seq_state_e;
endpackage

// [verif/adc_model.sv]
/* Behavioural converter answering each start with a done pulse.
   Assumes starts arrive one at a time on aclk. */
`timescale 1ns/1ps
`default_nettype none
module adc_model
   import pmon_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic adc_start,
   input wire logic adc_channel,
   input wire logic slow,
   input wire logic [ADC_W-1:0] cur_val,
   input wire logic [ADC_W-1:0] volt_val,
   output logic adc_done,
   output logic [ADC_W-1:0] adc_result
);
   int cnt;
   logic ch;
   // Result lines toggle outside the pulse so late sampling is caught.
   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt <= 0;
         adc_done <= 1'b0;
         adc_result <= 12'h000;
      end else begin
         adc_done <= 1'b0;
         adc_result <= ~adc_result;
         if (adc_start) begin
            cnt <= slow ? 4 : 1;
            ch <= adc_channel;
         end else if (cnt == 1) begin
            adc_done <= 1'b1;
            adc_result <= (ch == CHAN_VOLT) ? volt_val : cur_val;
            cnt <= 0;
         end else if (cnt > 1) begin
            cnt <= cnt - 1;
         end
      end
   end
endmodule
`default_nettype wire

// [verif/pmon_properties.sv]
/* Concurrent checks on the power monitor control pins.
   Bound into the top module; sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module pmon_properties
   import pmon_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic convert_pin,
   input wire logic supply_lockout,
   input wire logic [1:0] address_select_low,
   input wire logic [1:0] address_select_high,
   input wire logic adc_start,
   input wire logic adc_channel,
   input wire logic overcurrent_alert_n,
   input wire logic overcurrent_alert_oe,
   input wire logic [6:0] slave_address
);
   // ----------
   // Helpers
   // ----------
   // A lockout resets the block late, so checks rest until it has surely passed.
   logic [5:0] lk_r;
   logic [1:0] wv_r;
   logic lk;
   assign lk = supply_lockout | (|lk_r);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lk_r <= 6'h00;
         wv_r <= 2'h0;
      end else begin
         lk_r <= {lk_r[4:0], supply_lockout};
         wv_r <= {wv_r[0], s_axi_wvalid};
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn || lk);
   // ----------
   // Properties
   // ----------
   property p_start;
      adc_start |=> !adc_start;
   endproperty
   a_start: assert property (p_start) else $error("start not a pulse");
   property p_idle;
      (!convert_pin)[*8] ##1 (!convert_pin)[*8] |-> !adc_start;
   endproperty
   a_idle: assert property (p_idle) else $error("start with pin low");
   property p_chan;
      $changed(adc_channel) |-> adc_start;
   endproperty
   a_chan: assert property (p_chan) else $error("channel moved mid conversion");
   property p_lock;
      @(posedge aclk) disable iff (!aresetn)
      supply_lockout[*4] |=> !overcurrent_alert_oe && !s_axi_awready;
   endproperty
   a_lock: assert property (p_lock) else $error("logic alive in lockout");
   property p_drive;
      overcurrent_alert_oe |-> overcurrent_alert_n == 1'b0;
   endproperty
   a_drive: assert property (p_drive) else $error("alert drives high");
   property p_latch;
      overcurrent_alert_oe && !s_axi_wvalid && wv_r == 2'h0 |=> overcurrent_alert_oe;
   endproperty
   a_latch: assert property (p_latch) else $error("alert dropped alone");
   property p_straps;
      ($stable(address_select_low) && $stable(address_select_high))[*8]
         |-> slave_address[3:0] == {address_select_high, address_select_low};
   endproperty
   a_straps: assert property (p_straps) else $error("strap decode wrong");
   property p_base;
      slave_address[6:4] == SLAVE_ADDR_BASE;
   endproperty
   a_base: assert property (p_base) else $error("address base wrong");
endmodule
bind power_monitor_convert_pin_alert_ctrl pmon_properties chk_i (.*);
`default_nettype wire

// [verif/tb_top.sv]
/* Self-checking bench for the power monitor control block.
   Drives AXI4-Lite, pins and straps; a converter model answers starts. */
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import pmon_pkg::*;
;
   logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b0, convert_pin = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic threshold_voltage_input = 1'b0, supply_lockout = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] address_select_low = 2'h0, address_select_high = 2'h0;
   logic [ADC_W-1:0] cur_val = 12'h000, volt_val = 12'h000, ec, ev, adc_result;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic adc_start, adc_channel, adc_done, overcurrent_alert_n, overcurrent_alert_oe;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [31:0] s_axi_rdata, rdv;
   logic [6:0] slave_address;
   int miscompares = 0, check_count = 0, nc = 0, nv = 0, nd = 0;
   power_monitor_convert_pin_alert_ctrl DUT (.*);
   adc_model partner (.*);
   always #10 aclk = ~aclk;
   always @(posedge aclk) begin
      if (adc_start === 1'b1) begin
         if (adc_channel === CHAN_VOLT) nv <= nv + 1;
         else nc <= nc + 1;
      end
      if (adc_done === 1'b1) nd <= nd + 1;
   end
   // ----------
   // Bus and compare tasks
   // ----------
   task automatic close_out;
      if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic tmo(input logic bad);
      if (bad) begin
         miscompares++;
         close_out();
      end
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 40 && s_axi_bvalid !== 1'b1; n++) begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end
      tmo(n == 40);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 40 && s_axi_rvalid !== 1'b1; n++) begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end
      tmo(n == 40);
      rdv = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // ----------
   // Scenarios
   // ----------
   task automatic t_map;
      rd(OFS_CONVERT_PIN_CTRL);
      chk(rdv, {30'h0, CONVERT_PIN_MODE_RST});
      rd(OFS_ALERT_THRESHOLD_REG);
      chk(rdv, {20'h0, ALERT_THRESHOLD_REG_RST});
      rd(8'h18);
      chk(rsp, RESP_SLVERR);
      wr(8'h1C, 32'h5);
      chk(rsp, RESP_SLVERR);
      s_axi_wstrb <= 4'h2;
      wr(OFS_ALERT_THRESHOLD_REG, 32'h0A55);
      s_axi_wstrb <= 4'hF;
      rd(OFS_ALERT_THRESHOLD_REG);
      chk(rdv, {20'h0, 12'hAFF});
   endtask
   task automatic t_addr;
      for (int i = 0; i < 16; i++) begin
         {address_select_high, address_select_low} <= i[3:0];
         repeat (6) @(posedge aclk);
         chk(slave_address, {SLAVE_ADDR_BASE, i[3:0]});
      end
      rd(OFS_STATUS);
      chk(rdv[14:8], {SLAVE_ADDR_BASE, 4'hF});
   endtask
   task automatic t_convert_pin(input logic [1:0] m, input logic [11:0] c, input logic [11:0] v);
      int n, k, c0, v0, d0;
      logic cs, vs;
      cs = (m == MODE_CUR) || (m == MODE_BOTH);
      vs = (m == MODE_VOLT) || (m == MODE_BOTH);
      k = int'(cs) + int'(vs);
      wr(OFS_CONVERT_PIN_CTRL, {30'h0, m});
      cur_val <= c;
      volt_val <= v;
      slow <= c[0];
      c0 = nc;
      v0 = nv;
      d0 = nd;
      convert_pin <= 1'b1;
      for (n = 0; n < 60 && (k == 0 || nd - d0 < k); n++) @(posedge aclk);
      tmo(n == 60 && k != 0);
      convert_pin <= 1'b0;
      repeat (4) @(posedge aclk);
      for (n = 0; n < 40; n++) begin
         rd(OFS_STATUS);
         if (rdv[ST_BUSY_BIT] === 1'b0) break;
      end
      tmo(n == 40);
      if (cs) ec = c;
      if (vs) ev = v;
      chk(nc != c0, cs);
      chk(nv != v0, vs);
      rd(OFS_CUR_DATA);
      chk(rdv, {20'h0, ec});
      rd(OFS_VOLT_DATA);
      chk(rdv, {20'h0, ev});
   endtask
   task automatic t_cont;
      int c0;
      wr(OFS_CONVERT_PIN_CTRL, {30'h0, MODE_CUR});
      slow <= 1'b0;
      c0 = nc;
      convert_pin <= 1'b1;
      repeat (40) @(posedge aclk);
      chk(nc - c0 >= 4, 1'b1);
      convert_pin <= 1'b0;
      repeat (20) @(posedge aclk);
      c0 = nc;
      repeat (20) @(posedge aclk);
      chk(nc - c0, 0);
   endtask
   task automatic t_cmp;
      wr(OFS_ALERT_EN, 32'h0);
      threshold_voltage_input <= 1'b1;
      repeat (5) @(posedge aclk);
      threshold_voltage_input <= 1'b0;
      repeat (5) @(posedge aclk);
      chk(overcurrent_alert_oe, 1'b1);
      chk(overcurrent_alert_n, 1'b0);
      rd(OFS_STATUS);
      chk(rdv[ST_ALERT_BIT], 1'b1);
      wr(OFS_ALERT_EN, 32'h2);
      repeat (2) @(posedge aclk);
      chk(overcurrent_alert_oe, 1'b0);
   endtask
   task automatic t_reg;
      wr(OFS_ALERT_EN, 32'h1);
      wr(OFS_ALERT_THRESHOLD_REG, 32'h100);
      threshold_voltage_input <= 1'b1;
      t_convert_pin(MODE_CUR, 12'h100, 12'h000);
      chk(overcurrent_alert_oe, 1'b0);
      threshold_voltage_input <= 1'b0;
      t_convert_pin(MODE_CUR, 12'h101, 12'h000);
      chk(overcurrent_alert_oe, 1'b1);
      wr(OFS_ALERT_EN, 32'h3);
      rd(OFS_ALERT_EN);
      chk(rdv, 32'h1);
      chk(overcurrent_alert_oe, 1'b0);
   endtask
   task automatic t_lock;
      wr(OFS_ALERT_THRESHOLD_REG, 32'h123);
      supply_lockout <= 1'b1;
      repeat (5) @(posedge aclk);
      chk(s_axi_awready, 1'b0);
      supply_lockout <= 1'b0;
      repeat (6) @(posedge aclk);
      rd(OFS_ALERT_THRESHOLD_REG);
      chk(rdv, {20'h0, ALERT_THRESHOLD_REG_RST});
   endtask
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      t_map();
      t_addr();
      t_convert_pin(MODE_BOTH, 12'hA5C, 12'h3C7);
      t_convert_pin(MODE_CUR, 12'h0F1, 12'h222);
      t_convert_pin(MODE_VOLT, 12'h444, 12'h5B6);
      t_convert_pin(MODE_NONE, 12'h777, 12'h888);
      t_cont();
      t_cmp();
      t_reg();
      t_lock();
      close_out();
   end
endmodule
`default_nettype wire

// [verilog/convert_pin_sequencer.sv]
/*
 Conversion sequencer: starts current and/or voltage conversions while the trigger is high.
 Assumes the converter answers each start with a one-cycle done pulse on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module convert_pin_sequencer
   import pmon_pkg::*;
(
   input wire logic aclk,
   input wire logic rst_n,
   input wire logic trigger,
   input wire logic [1:0] mode,
   input wire logic adc_done,
   input wire logic [ADC_W-1:0] adc_result,
   output logic adc_start,
   output logic adc_channel,
   output logic busy,
   output logic cur_new,
   output convert_pin_result_s result
);
   seq_state_e state_r, state_nxt;
   logic start_r, start_nxt;
   logic chan_r, chan_nxt;
   logic new_r, new_nxt;
   convert_pin_result_s res_r, res_nxt;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      state_nxt = state_r;
      start_nxt = 1'b0;
      chan_nxt = chan_r;
      new_nxt = 1'b0;
      res_nxt = res_r;
      unique case (state_r)
         SEQ_IDLE: begin
            // A held-high trigger restarts here, so the converter runs continuously.
            if (trigger && mode != MODE_NONE) begin
               start_nxt = 1'b1;
               if (mode == MODE_VOLT) begin
                  state_nxt = SEQ_VOLT;
                  chan_nxt = CHAN_VOLT;
               end else begin
                  state_nxt = SEQ_CUR;
                  chan_nxt = CHAN_CUR;
               end
            end
         end
         SEQ_CUR: begin
            if (adc_done) begin
               res_nxt.cur = adc_result;
               new_nxt = 1'b1;
               if (mode == MODE_BOTH) begin
                  state_nxt = SEQ_VOLT;
                  chan_nxt = CHAN_VOLT;
                  start_nxt = 1'b1;
               end else begin
                  state_nxt = SEQ_IDLE;
               end
            end
         end
         SEQ_VOLT: begin
            if (adc_done) begin
               res_nxt.volt = adc_result;
               state_nxt = SEQ_IDLE;
            end
         end
         default: state_nxt = SEQ_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!rst_n) begin
         state_r <= SEQ_IDLE;
         start_r <= 1'b0;
         chan_r <= CHAN_CUR;
         new_r <= 1'b0;
         res_r <= '0;
      end else begin
         state_r <= state_nxt;
         start_r <= start_nxt;
         chan_r <= chan_nxt;
         new_r <= new_nxt;
         res_r <= res_nxt;
      end
   end

   assign adc_start = start_r;
   assign adc_channel = chan_r;
   assign busy = (state_r != SEQ_IDLE);
   assign cur_new = new_r;
   assign result = res_r;
endmodule
`default_nettype wire

// [verilog/power_monitor_convert_pin_alert_ctrl.sv]
/*
 Top of the power monitor control: AXI4-Lite registers, convert pin, latched overcurrent
 alert, supply lockout reset and address strap decode.
 Assumes pins arrive asynchronously and the converter front end runs on aclk.
*/
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - A high level sampled on the convert pin starts a conversion unless the control register selects no channel.
// - The control register chooses current only, voltage only or both channels.
// - All logic except the pin synchronisers is held in reset while the supply lockout reports low supply.
// - The alert pin is pulled low on overcurrent and released when software clears it.
// - The alert enable register selects comparator or threshold register as source.
// - The alert stays latched until software clears it through the alert enable register.
// - Each address pin is decoded as one of four states, giving sixteen addresses.
// - The slave address is 011 followed by the two decoded pin states.
module power_monitor_convert_pin_alert_ctrl
   import pmon_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic convert_pin,
   input wire logic threshold_voltage_input,
   input wire logic supply_lockout,
   input wire logic [1:0] address_select_low,
   input wire logic [1:0] address_select_high,
   input wire logic adc_done,
   input wire logic [ADC_W-1:0] adc_result,
   output logic adc_start,
   output logic adc_channel,
   output logic overcurrent_alert_n,
   output logic overcurrent_alert_oe,
   output logic [6:0] slave_address
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [1:0] convert_pin_sync_r, cmp_sync_r, lock_sync_r;
   logic [3:0] addr_meta_r, addr_sync_r;
   logic rst_n;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         convert_pin_sync_r <= 2'h0;
         cmp_sync_r <= 2'h0;
         lock_sync_r <= 2'h3;
         addr_meta_r <= 4'h0;
         addr_sync_r <= 4'h0;
      end else begin
         convert_pin_sync_r <= {convert_pin_sync_r[0], convert_pin};
         cmp_sync_r <= {cmp_sync_r[0], threshold_voltage_input};
         lock_sync_r <= {lock_sync_r[0], supply_lockout};
         addr_meta_r <= {address_select_high, address_select_low};
         addr_sync_r <= addr_meta_r;
      end
   end

   assign rst_n = aresetn & ~lock_sync_r[1];

   // ----------------------------------------
   // Conversion sequencer
   // ----------------------------------------
   logic [1:0] convert_pin_mode_r, convert_pin_mode_nxt;
   logic seq_busy, cur_new;
   convert_pin_result_s result;

   convert_pin_sequencer u_seq (
      .aclk(aclk),
      .rst_n(rst_n),
      .trigger(convert_pin_sync_r[1]),
      .mode(convert_pin_mode_r),
      .adc_done(adc_done),
      .adc_result(adc_result),
      .adc_start(adc_start),
      .adc_channel(adc_channel),
      .busy(seq_busy),
      .cur_new(cur_new),
      .result(result)
   );

   // ----------------------------------------
   // Register bus and alert state
   // ----------------------------------------
   logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
   logic [7:0] waddr_r, waddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic awready_r, awready_nxt, wready_r, wready_nxt;
   logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic alert_src_r, alert_src_nxt;
   logic [ADC_W-1:0] alert_threshold_reg_r, alert_threshold_reg_nxt;
   logic alert_r, alert_nxt, alert_set, alert_clr;
   logic [6:0] addr_r, addr_nxt;
   logic [31:0] merged;

   // Byte-lane merge so partial writes leave untouched lanes alone.
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
      logic [31:0] m;
      m = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            m[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return m;
   endfunction

   function automatic logic reg_mapped(input logic [7:0] a);
      return a == OFS_CONVERT_PIN_CTRL || a == OFS_ALERT_EN || a == OFS_ALERT_THRESHOLD_REG ||
             a == OFS_STATUS || a == OFS_CUR_DATA || a == OFS_VOLT_DATA;
   endfunction

   always_comb begin
      aw_full_nxt = aw_full_r;
      w_full_nxt = w_full_r;
      waddr_nxt = waddr_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      arready_nxt = arready_r;
      rvalid_nxt = rvalid_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      convert_pin_mode_nxt = convert_pin_mode_r;
      alert_src_nxt = alert_src_r;
      alert_threshold_reg_nxt = alert_threshold_reg_r;
      alert_clr = 1'b0;
      merged = 32'h0;
      if (s_axi_awvalid && awready_r) begin
         aw_full_nxt = 1'b1;
         waddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_r) begin
         w_full_nxt = 1'b1;
         wdata_nxt = s_axi_wdata;
         wstrb_nxt = s_axi_wstrb;
      end
      if (aw_full_r && w_full_r && !bvalid_r) begin
         aw_full_nxt = 1'b0;
         w_full_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = reg_mapped(waddr_r) ? RESP_OKAY : RESP_SLVERR;
         unique case (waddr_r)
            OFS_CONVERT_PIN_CTRL: begin
               merged = lane_merge({30'h0, convert_pin_mode_r}, wdata_r, wstrb_r);
               convert_pin_mode_nxt = merged[1:0];
            end
            OFS_ALERT_EN: begin
               merged = lane_merge({31'h0, alert_src_r}, wdata_r, wstrb_r);
               alert_src_nxt = merged[AEN_SRC_BIT];
               alert_clr = wstrb_r[0] & wdata_r[AEN_CLR_BIT];
            end
            OFS_ALERT_THRESHOLD_REG: begin
               merged = lane_merge({20'h0, alert_threshold_reg_r}, wdata_r, wstrb_r);
               alert_threshold_reg_nxt = merged[ADC_W-1:0];
            end
            default: ;
         endcase
      end else if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (s_axi_arvalid && arready_r) begin
         arready_nxt = 1'b0;
         rvalid_nxt = 1'b1;
         rresp_nxt = reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         unique case (s_axi_araddr)
            OFS_CONVERT_PIN_CTRL: rdata_nxt = {30'h0, convert_pin_mode_r};
            OFS_ALERT_EN: rdata_nxt = {31'h0, alert_src_r};
            OFS_ALERT_THRESHOLD_REG: rdata_nxt = {20'h0, alert_threshold_reg_r};
            OFS_STATUS: rdata_nxt = {17'h0, addr_r, 6'h0, seq_busy, alert_r};
            OFS_CUR_DATA: rdata_nxt = {20'h0, result.cur};
            OFS_VOLT_DATA: rdata_nxt = {20'h0, result.volt};
            default: rdata_nxt = 32'h0;
         endcase
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
         arready_nxt = 1'b1;
      end
      awready_nxt = ~aw_full_nxt & ~bvalid_nxt;
      wready_nxt = ~w_full_nxt & ~bvalid_nxt;
      // A read address is refused while a read answer still stands.
      arready_nxt = ~rvalid_nxt;
      // A new overcurrent in the clearing cycle keeps the latch set.
      alert_set = alert_src_r ? (cur_new && result.cur > alert_threshold_reg_r)
                              : cmp_sync_r[1];
      alert_nxt = alert_set | (alert_r & ~alert_clr);
      addr_nxt = {SLAVE_ADDR_BASE, addr_sync_r[3:2], addr_sync_r[1:0]};
   end

   always_ff @(posedge aclk) begin
      if (!rst_n) begin
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         waddr_r <= 8'h0;
         wdata_r <= 32'h0;
         wstrb_r <= 4'h0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rresp_r <= RESP_OKAY;
         rdata_r <= 32'h0;
         convert_pin_mode_r <= CONVERT_PIN_MODE_RST;
         alert_src_r <= 1'b0;
         alert_threshold_reg_r <= ALERT_THRESHOLD_REG_RST;
         alert_r <= 1'b0;
         addr_r <= {SLAVE_ADDR_BASE, 4'h0};
      end else begin
         aw_full_r <= aw_full_nxt;
         w_full_r <= w_full_nxt;
         waddr_r <= waddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
         convert_pin_mode_r <= convert_pin_mode_nxt;
         alert_src_r <= alert_src_nxt;
         alert_threshold_reg_r <= alert_threshold_reg_nxt;
         alert_r <= alert_nxt;
         addr_r <= addr_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;
   // Open drain: the pin value is always low and only the enable moves.
   assign overcurrent_alert_n = 1'b0;
   assign overcurrent_alert_oe = alert_r;
   assign slave_address = addr_r;
endmodule
`default_nettype wire
